// ### common/macctl_defines.svh
// offsets, bit positions and reset values of the mac control block
// assumes a 32-bit register port with word addresses in bytes
`ifndef MACCTL_DEFINES_SVH
`define MACCTL_DEFINES_SVH

// ========================================
// register offsets
`define MACCTL_OFS_CONTROL 8'h00
`define MACCTL_OFS_INT_STATUS 8'h04
`define MACCTL_OFS_INT_MASK 8'h08

// ========================================
// mac_control bit positions
`define MACCTL_BIT_PAUSE_HONOR 8
`define MACCTL_BIT_COLLISION 16
`define MACCTL_BIT_CARRIER 17
`define MACCTL_BIT_STATS_START 21
`define MACCTL_BIT_STATS_STOP 22
`define MACCTL_BIT_STATS_RUN 23
`define MACCTL_BIT_TX_START 24
`define MACCTL_BIT_TX_STOP 25
`define MACCTL_BIT_TX_RUN 26
`define MACCTL_BIT_RX_START 27
`define MACCTL_BIT_RX_STOP 28
`define MACCTL_BIT_RX_RUN 29
`define MACCTL_BIT_PAUSED 30

// ========================================
// interrupt status bits
`define MACCTL_IRQ_PAUSE_SET 0
`define MACCTL_IRQ_PAUSE_END 1
`define MACCTL_IRQ_COUNT 2

// ========================================
// reset values
`define MACCTL_RST_DATA 32'h0000_0000
`define MACCTL_RST_IRQ 2'h0

`endif

// ### common/macctl_pkg.sv
// types shared by the mac control block
// no constants here; those sit in macctl_defines.svh
package macctl_pkg;

    // register port request
    typedef struct packed
    {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } macctl_req_type;

    // start/stop commands of one function
    typedef struct packed
    {
        logic start;
        logic stop;
    } macctl_cmd_type;

    // pause sequencer states
    typedef enum logic [0:0]
    {
        MACCTL_RUNNING,
        MACCTL_HALTED
    } macctl_pause_type;

endpackage

// ### core/macctl_regs.sv
// upper half of the mac control register with pause tracking and interrupts
// assumes collision, carrier and pause events are synchronous to clk
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "macctl_defines.svh"

// Function
// - bit 16 reads live collision level
// - bit 17 reads live carrier level
// - bit 21 write starts statistics, self-clearing
// - bit 22 write freezes statistics, self-clearing
// - bit 23 shows statistics counting active
// - bit 24 write enables transmitter, self-clearing
// - bit 25 write disables transmitter, self-clearing
// - bit 26 shows transmitter enabled
// - bit 27 write enables receiver, self-clearing
// - bit 28 write disables receiver, self-clearing
// - bit 29 shows receiver enabled
// - bit 30 set while pause halts transmit
// - pause acted on only when honoring enabled
module macctl_regs
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire macctl_pkg::macctl_req_type bus_req,
    output logic [31:0] bus_rdata,
    // line status from the mii side
    input wire logic collision_live,
    input wire logic carrier_live,
    // pause frame events from the receive mac
    input wire logic pause_rx,
    input wire logic pause_done,
    // function enables
    output logic stats_running,
    output logic tx_running,
    output logic rx_running,
    output logic tx_paused,
    // interrupt
    output logic irq
);

    // ========================================
    // decode
    logic wr_ctl;
    logic wr_sts;
    logic wr_msk;
    macctl_pkg::macctl_cmd_type stats_cmd;
    macctl_pkg::macctl_cmd_type tx_cmd;
    macctl_pkg::macctl_cmd_type rx_cmd;

    // pick one command pair out of the write data
    function automatic macctl_pkg::macctl_cmd_type cmd_of(input logic [31:0] d,
        input int unsigned pos);
        macctl_pkg::macctl_cmd_type c;
        c.start = d[pos];
        c.stop = d[pos + 1];
        return c;
    endfunction

    // commands live only in the write cycle, so they clear themselves
    assign wr_ctl = bus_req.wr && (bus_req.addr == `MACCTL_OFS_CONTROL);
    assign wr_sts = bus_req.wr && (bus_req.addr == `MACCTL_OFS_INT_STATUS);
    assign wr_msk = bus_req.wr && (bus_req.addr == `MACCTL_OFS_INT_MASK);
    assign stats_cmd = wr_ctl ? cmd_of(bus_req.wdata, `MACCTL_BIT_STATS_START) : 2'h0;
    assign tx_cmd = wr_ctl ? cmd_of(bus_req.wdata, `MACCTL_BIT_TX_START) : 2'h0;
    assign rx_cmd = wr_ctl ? cmd_of(bus_req.wdata, `MACCTL_BIT_RX_START) : 2'h0;

    // ========================================
    // run flags
    logic stats_run_ff;
    logic tx_run_ff;
    logic rx_run_ff;
    logic pause_honor_ff;

    // stop tested first so a write with both bits ends disabled
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stats_run_ff <= 1'b0;
            tx_run_ff <= 1'b0;
            rx_run_ff <= 1'b0;
        end
        else
        begin
            if (stats_cmd.stop)
                stats_run_ff <= 1'b0;
            else if (stats_cmd.start)
                stats_run_ff <= 1'b1;
            if (tx_cmd.stop)
                tx_run_ff <= 1'b0;
            else if (tx_cmd.start)
                tx_run_ff <= 1'b1;
            if (rx_cmd.stop)
                rx_run_ff <= 1'b0;
            else if (rx_cmd.start)
                rx_run_ff <= 1'b1;
        end
    end

    // honoring of pause frames, a plain r/w bit
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pause_honor_ff <= 1'b0;
        else if (wr_ctl)
            pause_honor_ff <= bus_req.wdata[`MACCTL_BIT_PAUSE_HONOR];
    end

    // ========================================
    // pause tracking
    macctl_pkg::macctl_pause_type pause_st_ff;
    logic pause_take;
    logic pause_leave;

    // without honoring, a pause frame is ordinary data and changes nothing
    assign pause_take = pause_rx && pause_honor_ff && (pause_st_ff == macctl_pkg::MACCTL_RUNNING);
    assign pause_leave = pause_done && (pause_st_ff == macctl_pkg::MACCTL_HALTED);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pause_st_ff <= macctl_pkg::MACCTL_RUNNING;
        else
        begin
            unique case (pause_st_ff)
                macctl_pkg::MACCTL_RUNNING:
                    if (pause_take)
                        pause_st_ff <= macctl_pkg::MACCTL_HALTED;
                macctl_pkg::MACCTL_HALTED:
                    if (pause_done)
                        pause_st_ff <= macctl_pkg::MACCTL_RUNNING;
            endcase
        end
    end

    // ========================================
    // interrupts
    logic [`MACCTL_IRQ_COUNT-1:0] irq_sts_ff;
    logic [`MACCTL_IRQ_COUNT-1:0] irq_msk_ff;
    logic [`MACCTL_IRQ_COUNT-1:0] irq_evt;

    assign irq_evt = {pause_leave, pause_take};

    // a new event wins over a write-one clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_sts_ff <= `MACCTL_RST_IRQ;
        else
            irq_sts_ff <= (irq_sts_ff & ~(wr_sts ? bus_req.wdata[1:0] : 2'h0)) | irq_evt;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            irq_msk_ff <= `MACCTL_RST_IRQ;
        else if (wr_msk)
            irq_msk_ff <= bus_req.wdata[1:0];
    end

    assign irq = |(irq_sts_ff & irq_msk_ff);

    // ========================================
    // read path
    logic [31:0] nxt_rdata;
    logic [31:0] rdata_ff;

    // live bits sampled in the read cycle; reserved and command bits read zero
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                `MACCTL_OFS_CONTROL:
                begin
                    nxt_rdata[`MACCTL_BIT_PAUSE_HONOR] = pause_honor_ff;
                    nxt_rdata[`MACCTL_BIT_COLLISION] = collision_live;
                    nxt_rdata[`MACCTL_BIT_CARRIER] = carrier_live;
                    nxt_rdata[`MACCTL_BIT_STATS_RUN] = stats_run_ff;
                    nxt_rdata[`MACCTL_BIT_TX_RUN] = tx_run_ff;
                    nxt_rdata[`MACCTL_BIT_RX_RUN] = rx_run_ff;
                    nxt_rdata[`MACCTL_BIT_PAUSED] =
                        (pause_st_ff == macctl_pkg::MACCTL_HALTED);
                end
                `MACCTL_OFS_INT_STATUS: nxt_rdata[1:0] = irq_sts_ff;
                `MACCTL_OFS_INT_MASK: nxt_rdata[1:0] = irq_msk_ff;
                default: nxt_rdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_ff <= `MACCTL_RST_DATA;
        else
            rdata_ff <= nxt_rdata;
    end

    assign bus_rdata = rdata_ff;
    assign stats_running = stats_run_ff;
    assign tx_running = tx_run_ff;
    assign rx_running = rx_run_ff;
    assign tx_paused = (pause_st_ff == macctl_pkg::MACCTL_HALTED);

    // ========================================
    // checks
    a_coll_live: assert property (@(posedge clk) disable iff (sys_rst)
        bus_req.rd && bus_req.addr == `MACCTL_OFS_CONTROL
        |=> bus_rdata[`MACCTL_BIT_COLLISION] == $past(collision_live))
        else $error("collision bit not live");
    a_carr_live: assert property (@(posedge clk) disable iff (sys_rst)
        bus_req.rd && bus_req.addr == `MACCTL_OFS_CONTROL
        |=> bus_rdata[`MACCTL_BIT_CARRIER] == $past(carrier_live))
        else $error("carrier bit not live");
    a_stats_start: assert property (@(posedge clk) disable iff (sys_rst)
        stats_cmd.start && !stats_cmd.stop |=> stats_running)
        else $error("statistics did not start");
    a_stats_stop: assert property (@(posedge clk) disable iff (sys_rst)
        stats_cmd.stop |=> !stats_running)
        else $error("statistics did not stop");
    a_stats_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !wr_ctl |=> $stable(stats_running))
        else $error("statistics flag moved without command");
    a_tx_start: assert property (@(posedge clk) disable iff (sys_rst)
        tx_cmd.start && !tx_cmd.stop |=> tx_running)
        else $error("transmitter did not start");
    a_tx_stop: assert property (@(posedge clk) disable iff (sys_rst)
        tx_cmd.stop |=> !tx_running)
        else $error("transmitter did not stop");
    a_tx_readback: assert property (@(posedge clk) disable iff (sys_rst)
        bus_req.rd && bus_req.addr == `MACCTL_OFS_CONTROL
        |=> bus_rdata[`MACCTL_BIT_TX_RUN] == $past(tx_running))
        else $error("transmit status wrong");
    a_rx_start: assert property (@(posedge clk) disable iff (sys_rst)
        rx_cmd.start && !rx_cmd.stop |=> rx_running)
        else $error("receiver did not start");
    a_rx_stop: assert property (@(posedge clk) disable iff (sys_rst)
        rx_cmd.stop |=> !rx_running)
        else $error("receiver did not stop");
    a_rx_readback: assert property (@(posedge clk) disable iff (sys_rst)
        bus_req.rd && bus_req.addr == `MACCTL_OFS_CONTROL
        |=> bus_rdata[`MACCTL_BIT_RX_RUN] == $past(rx_running))
        else $error("receive status wrong");
    a_pause_set: assert property (@(posedge clk) disable iff (sys_rst)
        pause_rx && pause_honor_ff && !tx_paused |=> tx_paused)
        else $error("pause not entered");
    a_pause_end: assert property (@(posedge clk) disable iff (sys_rst)
        tx_paused && pause_done |=> !tx_paused)
        else $error("pause not left");
    a_pause_ignored: assert property (@(posedge clk) disable iff (sys_rst)
        !tx_paused && !pause_honor_ff |=> !tx_paused)
        else $error("pause taken while not honored");

    c_tx_on: cover property (@(posedge clk) disable iff (sys_rst) tx_cmd.start ##1 tx_running);
    c_both: cover property (@(posedge clk) disable iff (sys_rst) rx_cmd.start && rx_cmd.stop);
    c_pause: cover property (@(posedge clk) disable iff (sys_rst) pause_take ##[1:20] pause_leave);
    c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));

endmodule

// ### sim/tb_mac_control_status_upper.sv
// self-checking bench for the upper mac control register block
// assumes macctl_regs with the register port, offsets and bits of macctl_defines.svh
`timescale 1ns/1ns
`include "macctl_defines.svh"

module tb_mac_control_status_upper;

    // ========================================
    // signals
    logic clk;
    logic sys_rst;
    macctl_pkg::macctl_req_type bus_req;
    logic [31:0] bus_rdata;
    logic collision_live;
    logic carrier_live;
    logic pause_rx;
    logic pause_done;
    logic stats_running;
    logic tx_running;
    logic rx_running;
    logic tx_paused;
    logic irq;
    int errors;
    int samples_checked;
    int cycles;
    logic [31:0] rd_val;
    int run_bit[3];

    macctl_regs uut
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .collision_live(collision_live),
        .carrier_live(carrier_live),
        .pause_rx(pause_rx),
        .pause_done(pause_done),
        .stats_running(stats_running),
        .tx_running(tx_running),
        .rx_running(rx_running),
        .tx_paused(tx_paused),
        .irq(irq)
    );

    // ========================================
    // clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard: under a hundred cycles of work, generous ceiling
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            finish_test();
        end
    end

    // ========================================
    // tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one strobe cycle; returns at the edge that takes it, bus idle again
    task automatic bus_cycle(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
        @(posedge clk);
        bus_req <= '0;
        #1;
    endtask

    // reserved bits are always written as zero by the callers
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        bus_cycle(a, d, 1'b1);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        bus_cycle(a, 32'h0000_0000, 1'b0);
        d = bus_rdata;
    endtask

    task automatic pulse(input logic done);
        @(posedge clk);
        if (done)
            pause_done <= 1'b1;
        else
            pause_rx <= 1'b1;
        @(posedge clk);
        pause_done <= 1'b0;
        pause_rx <= 1'b0;
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [31:0] run_outs();
        return {29'h0000_0000, rx_running, tx_running, stats_running};
    endfunction

    // ========================================
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        bus_req = '0;
        collision_live = 1'b0;
        carrier_live = 1'b0;
        pause_rx = 1'b0;
        pause_done = 1'b0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        run_bit = '{`MACCTL_BIT_STATS_RUN, `MACCTL_BIT_TX_RUN, `MACCTL_BIT_RX_RUN};
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd_reg(`MACCTL_OFS_CONTROL, rd_val);
        check("control reset", rd_val, `MACCTL_RST_DATA);
        // live line levels, one then the other; moved on a rising edge only
        @(posedge clk);
        collision_live <= 1'b1;
        rd_reg(`MACCTL_OFS_CONTROL, rd_val);
        check("collision", rd_val, 32'h0001_0000);
        @(posedge clk);
        collision_live <= 1'b0;
        carrier_live <= 1'b1;
        rd_reg(`MACCTL_OFS_CONTROL, rd_val);
        check("carrier", rd_val, 32'h0002_0000);
        @(posedge clk);
        carrier_live <= 1'b0;
        // start, stop, then start and stop together for each function
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(`MACCTL_OFS_CONTROL, 32'h1 << (run_bit[i] - 2));
            check("run out start", run_outs(), 32'h1 << i);
            rd_reg(`MACCTL_OFS_CONTROL, rd_val);
            check("run bit start", rd_val, 32'h1 << run_bit[i]);
            wr_reg(`MACCTL_OFS_CONTROL, 32'h1 << (run_bit[i] - 1));
            check("run out stop", run_outs(), 32'h0000_0000);
            rd_reg(`MACCTL_OFS_CONTROL, rd_val);
            check("run bit stop", rd_val, 32'h0000_0000);
            wr_reg(`MACCTL_OFS_CONTROL, 32'h1 << (run_bit[i] - 2));
            wr_reg(`MACCTL_OFS_CONTROL, 32'h3 << (run_bit[i] - 2));
            check("run out both", run_outs(), 32'h0000_0000);
        end
        // pause frames are data while honoring is off
        pulse(1'b0);
        check("pause ignored", {31'h0, tx_paused}, 32'h0000_0000);
        rd_reg(`MACCTL_OFS_INT_STATUS, rd_val);
        check("status ignored", rd_val, 32'h0000_0000);
        wr_reg(`MACCTL_OFS_CONTROL, 32'h0000_0100);
        wr_reg(`MACCTL_OFS_INT_MASK, 32'h0000_0001);
        pulse(1'b0);
        check("paused out", {31'h0, tx_paused}, 32'h0000_0001);
        check("irq on pause", {31'h0, irq}, 32'h0000_0001);
        rd_reg(`MACCTL_OFS_CONTROL, rd_val);
        check("paused bit", rd_val, 32'h4000_0100);
        pulse(1'b1);
        check("resumed out", {31'h0, tx_paused}, 32'h0000_0000);
        rd_reg(`MACCTL_OFS_CONTROL, rd_val);
        check("resumed bit", rd_val, 32'h0000_0100);
        rd_reg(`MACCTL_OFS_INT_STATUS, rd_val);
        check("status both", rd_val, 32'h0000_0003);
        // clearing the unmasked event drops the line; masked one stays sticky
        wr_reg(`MACCTL_OFS_INT_STATUS, 32'h0000_0001);
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        rd_reg(`MACCTL_OFS_INT_STATUS, rd_val);
        check("status left", rd_val, 32'h0000_0002);
        rd_reg(`MACCTL_OFS_INT_MASK, rd_val);
        check("mask readback", rd_val, 32'h0000_0001);
        rd_reg(8'h0C, rd_val);
        check("unmapped read", rd_val, 32'h0000_0000);
        finish_test();
    end

endmodule
